/* File: hw/iparb_pkg.sv */
package iparb_pkg;

	// register byte addresses
	localparam logic [7:0] SE_STS_ADDR    = 8'h11;
	localparam logic [7:0] DIFF_STS_ADDR  = 8'h12;
	localparam logic [7:0] STBY_STS_ADDR  = 8'h14;
	localparam logic [7:0] SE_PRI_ADDR    = 8'h19;
	localparam logic [7:0] DIFF_PRI_ADDR  = 8'h1A;
	localparam logic [7:0] SEL_STS_ADDR   = 8'h1C;
	localparam logic [7:0] IRQ_STS_ADDR   = 8'h30;
	localparam logic [7:0] IRQ_MASK_ADDR  = 8'h31;

	// reset values
	localparam logic [7:0] SE_PRI_RST     = 8'h32;
	localparam logic [7:0] DIFF_PRI_RST   = 8'h00;
	localparam logic [5:0] IRQ_MASK_RST   = 6'h00;

	// alarm status word layout
	localparam int STS_SLAVE_ACT_BIT   = 5;
	localparam int STS_SLAVE_LOCK_BIT  = 4;
	localparam int STS_MASTER_ACT_BIT  = 1;
	localparam int STS_MASTER_LOCK_BIT = 0;

	// input indices
	localparam int NUM_INPUTS  = 5;
	localparam int IDX_MSE     = 0;
	localparam int IDX_SSE     = 1;
	localparam int IDX_MDIFF   = 2;
	localparam int IDX_SDIFF   = 3;
	localparam int IDX_STBY    = 4;
	localparam logic [3:0] STBY_RANK = 4'hF;

	// interrupt status layout
	localparam int IRQ_SEL_CHG_BIT = 5;

	// timing
	localparam longint CLK_HZ          = 125000000;
	localparam int     TICK_MS         = 1;
	localparam int     LOCK_TIMEOUT_S  = 100;
	localparam int unsigned TICK_CYCLES_DFLT = int'(CLK_HZ * TICK_MS / 1000);
	localparam int unsigned LOCK_TICKS_DFLT  = LOCK_TIMEOUT_S * 1000 / TICK_MS;
	localparam int CNT_W = 17;

	typedef struct packed {
		logic [3:0] slave;
		logic [3:0] master;
	} iparb_pri_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iparb_bus_t;

endpackage

/* File: hw/iparb_regs.sv */
`timescale 1ns/1ps
module iparb_regs #(
	parameter int unsigned TICK_CYCLES = iparb_pkg::TICK_CYCLES_DFLT,
	parameter int unsigned LOCK_TICKS  = iparb_pkg::LOCK_TICKS_DFLT
)(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       SRST,
	// register port
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	// monitor inputs
	input  wire logic [4:0] ACT_ALARM,
	input  wire logic       LOOP_LOCKED,
	// selection and interrupt
	output logic            SEL_VALID,
	output logic      [2:0] SEL_INPUT,
	output logic            IRQ
);

	iparb_pkg::iparb_bus_t bus;
	iparb_pkg::iparb_pri_t pri_se;
	iparb_pkg::iparb_pri_t pri_diff;
	iparb_pkg::iparb_pri_t wr_pri;
	logic [3:0]  rank [iparb_pkg::NUM_INPUTS];
	logic [4:0]  lock_alarm;
	logic [4:0]  alarm;
	logic [4:0]  valid;
	logic        next_valid;
	logic [2:0]  next_sel;
	logic [3:0]  best;
	logic [iparb_pkg::CNT_W-1:0] tick_cnt;
	logic [iparb_pkg::CNT_W-1:0] lock_cnt;
	logic        tick;
	logic        sel_change;
	logic        timeout;
	logic [5:0]  irq_sts;
	logic [5:0]  irq_mask;
	logic [5:0]  irq_set;
	logic [5:0]  irq_clr;
	logic        wr_se;
	logic        wr_diff;
	logic [7:0]  next_rdata;

	// bus request bundle
	assign bus     = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};
	assign wr_pri  = iparb_pkg::iparb_pri_t'(bus.wdata);
	assign wr_se   = bus.wr && (bus.addr == iparb_pkg::SE_PRI_ADDR);
	assign wr_diff = bus.wr && (bus.addr == iparb_pkg::DIFF_PRI_ADDR);

	// priority registers; a nonzero nibble written to one form clears the same field of the companion form
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			pri_se   <= iparb_pkg::iparb_pri_t'(iparb_pkg::SE_PRI_RST);
			pri_diff <= iparb_pkg::iparb_pri_t'(iparb_pkg::DIFF_PRI_RST);
		end
		else if (wr_se)
		begin
			pri_se <= wr_pri;
			if (wr_pri.master != 4'h0)
				pri_diff.master <= 4'h0;
			if (wr_pri.slave != 4'h0)
				pri_diff.slave <= 4'h0;
		end
		else if (wr_diff)
		begin
			pri_diff <= wr_pri;
			if (wr_pri.master != 4'h0)
				pri_se.master <= 4'h0;
			if (wr_pri.slave != 4'h0)
				pri_se.slave <= 4'h0;
		end
	end

	// ranks per input; stand-by has no rank field, so it ranks last as a fallback
	assign rank[iparb_pkg::IDX_MSE]   = pri_se.master;
	assign rank[iparb_pkg::IDX_SSE]   = pri_se.slave;
	assign rank[iparb_pkg::IDX_MDIFF] = pri_diff.master;
	assign rank[iparb_pkg::IDX_SDIFF] = pri_diff.slave;
	assign rank[iparb_pkg::IDX_STBY]  = iparb_pkg::STBY_RANK;

	// per-input qualification
	genvar gi;
	generate
		for (gi = 0; gi < iparb_pkg::NUM_INPUTS; gi++)
		begin : g_qual
			assign alarm[gi] = ACT_ALARM[gi] | lock_alarm[gi];
			assign valid[gi] = (rank[gi] != 4'h0) && !alarm[gi];

			// no qualified input may rank strictly below the one picked
			AST_SEL_LOWEST: assert property (@(posedge CLK) disable iff (SRST)
				valid[gi] |-> next_valid && rank[next_sel] <= rank[gi])
				else $error("a better ranked input was passed over");
		end
	endgenerate

	// lowest rank wins; strict compare gives ties to the lower index
	always_comb
	begin
		next_valid = 1'b0;
		next_sel   = 3'h0;
		best       = 4'hF;
		for (int i = 0; i < iparb_pkg::NUM_INPUTS; i++)
		begin
			if (valid[i] && (!next_valid || rank[i] < best))
			begin
				next_valid = 1'b1;
				next_sel   = 3'(i);
				best       = rank[i];
			end
		end
	end

	assign sel_change = (next_valid != SEL_VALID) || (next_valid && next_sel != SEL_INPUT);

	// registered selection
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			SEL_VALID <= 1'b0;
			SEL_INPUT <= 3'h0;
		end
		else
		begin
			SEL_VALID <= next_valid;
			SEL_INPUT <= next_sel;
		end
	end

	// millisecond tick keeps the lock timer narrow instead of a 34-bit cycle count
	always_ff @(posedge CLK)
	begin
		if (SRST || tick)
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 1'b1;
	end
	assign tick = (tick_cnt == iparb_pkg::CNT_W'(TICK_CYCLES - 1));

	// lock timer restarts whenever the source changes or lock is reported
	always_ff @(posedge CLK)
	begin
		if (SRST || !SEL_VALID || LOOP_LOCKED || sel_change || timeout)
			lock_cnt <= '0;
		else if (tick)
			lock_cnt <= lock_cnt + 1'b1;
	end
	assign timeout = tick && SEL_VALID && !LOOP_LOCKED && !sel_change &&
		(lock_cnt == iparb_pkg::CNT_W'(LOCK_TICKS - 1));

	// lock alarms; cleared by new activity alarm or by rewriting the rank register
	always_ff @(posedge CLK)
	begin
		if (SRST)
			lock_alarm <= 5'h00;
		else
		begin
			for (int i = 0; i < iparb_pkg::NUM_INPUTS; i++)
			begin
				if (timeout && SEL_INPUT == 3'(i))
					lock_alarm[i] <= 1'b1;
				else if (ACT_ALARM[i])
					lock_alarm[i] <= 1'b0;
				else if (wr_se && (i == iparb_pkg::IDX_MSE || i == iparb_pkg::IDX_SSE))
					lock_alarm[i] <= 1'b0;
				else if (wr_diff && (i == iparb_pkg::IDX_MDIFF || i == iparb_pkg::IDX_SDIFF))
					lock_alarm[i] <= 1'b0;
			end
		end
	end

	// interrupt events: lock alarm raised per input, selection changed
	always_comb
	begin
		irq_set = 6'h00;
		irq_set[iparb_pkg::IRQ_SEL_CHG_BIT] = sel_change;
		if (timeout)
			irq_set[SEL_INPUT] = 1'b1;
	end
	assign irq_clr = (bus.wr && bus.addr == iparb_pkg::IRQ_STS_ADDR) ? bus.wdata[5:0] : 6'h00;

	// sticky status; an event in the clearing cycle survives
	always_ff @(posedge CLK)
	begin
		if (SRST)
			irq_sts <= 6'h00;
		else
			irq_sts <= (irq_sts & ~irq_clr) | irq_set;
	end

	// interrupt mask
	always_ff @(posedge CLK)
	begin
		if (SRST)
			irq_mask <= iparb_pkg::IRQ_MASK_RST;
		else if (bus.wr && bus.addr == iparb_pkg::IRQ_MASK_ADDR)
			irq_mask <= bus.wdata[5:0];
	end

	assign IRQ = |(irq_sts & irq_mask);

	// alarm word with the shared layout
	function automatic logic [7:0] sts_word(input logic s_act, input logic s_lk,
		input logic m_act, input logic m_lk);
		logic [7:0] w;
		w = 8'h00;
		w[iparb_pkg::STS_SLAVE_ACT_BIT]   = s_act;
		w[iparb_pkg::STS_SLAVE_LOCK_BIT]  = s_lk;
		w[iparb_pkg::STS_MASTER_ACT_BIT]  = m_act;
		w[iparb_pkg::STS_MASTER_LOCK_BIT] = m_lk;
		return w;
	endfunction

	// read decode; unmapped addresses read zero
	always_comb
	begin
		next_rdata = 8'h00;
		unique case (bus.addr)
			iparb_pkg::SE_STS_ADDR:   next_rdata = sts_word(ACT_ALARM[1], lock_alarm[1],
				ACT_ALARM[0], lock_alarm[0]);
			iparb_pkg::DIFF_STS_ADDR: next_rdata = sts_word(ACT_ALARM[3], lock_alarm[3],
				ACT_ALARM[2], lock_alarm[2]);
			iparb_pkg::STBY_STS_ADDR: next_rdata = sts_word(1'b0, 1'b0,
				ACT_ALARM[4], lock_alarm[4]);
			iparb_pkg::SE_PRI_ADDR:   next_rdata = pri_se;
			iparb_pkg::DIFF_PRI_ADDR: next_rdata = pri_diff;
			iparb_pkg::SEL_STS_ADDR:  next_rdata = {SEL_VALID, 4'h0, SEL_INPUT};
			iparb_pkg::IRQ_STS_ADDR:  next_rdata = {2'h0, irq_sts};
			iparb_pkg::IRQ_MASK_ADDR: next_rdata = {2'h0, irq_mask};
			default:                  next_rdata = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge CLK)
	begin
		if (SRST || !bus.rd)
			RDATA <= 8'h00;
		else
			RDATA <= next_rdata;
	end

	// checks
	AST_SE_CLR_MDIFF: assert property (@(posedge CLK) disable iff (SRST)
		wr_se && WDATA[3:0] != 4'h0 |=> pri_diff.master == 4'h0 && pri_se.master == $past(WDATA[3:0]))
		else $error("master differential rank not cleared");

	AST_SE_CLR_SDIFF: assert property (@(posedge CLK) disable iff (SRST)
		wr_se && WDATA[7:4] != 4'h0 |=> pri_diff.slave == 4'h0 && pri_se.slave == $past(WDATA[7:4]))
		else $error("slave differential rank not cleared");

	AST_DIFF_CLR_MSE: assert property (@(posedge CLK) disable iff (SRST)
		wr_diff && WDATA[3:0] != 4'h0 |=> pri_se.master == 4'h0 && pri_diff.master == $past(WDATA[3:0]))
		else $error("master single-ended rank not cleared");

	AST_DIFF_CLR_SSE: assert property (@(posedge CLK) disable iff (SRST)
		wr_diff && WDATA[7:4] != 4'h0 |=> pri_se.slave == 4'h0 && pri_diff.slave == $past(WDATA[7:4]))
		else $error("slave single-ended rank not cleared");

	// a zero nibble leaves the companion form alone; both registers never write together
	AST_ZERO_KEEPS: assert property (@(posedge CLK) disable iff (SRST)
		wr_se && WDATA[3:0] == 4'h0 |=> pri_diff.master == $past(pri_diff.master))
		else $error("zero write disturbed companion rank");

	AST_ZERO_KEEPS_SLV: assert property (@(posedge CLK) disable iff (SRST)
		wr_se && WDATA[7:4] == 4'h0 |=> pri_diff.slave == $past(pri_diff.slave))
		else $error("zero slave write disturbed companion rank");

	AST_DZERO_KEEPS_MST: assert property (@(posedge CLK) disable iff (SRST)
		wr_diff && WDATA[3:0] == 4'h0 |=> pri_se.master == $past(pri_se.master))
		else $error("zero differential write disturbed master rank");

	AST_DZERO_KEEPS_SLV: assert property (@(posedge CLK) disable iff (SRST)
		wr_diff && WDATA[7:4] == 4'h0 |=> pri_se.slave == $past(pri_se.slave))
		else $error("zero differential write disturbed slave rank");

	AST_PRI_READ: assert property (@(posedge CLK) disable iff (SRST)
		RD && ADDR == iparb_pkg::SE_PRI_ADDR |=> RDATA == $past(pri_se))
		else $error("priority read mismatch");

	AST_ACT_BITS: assert property (@(posedge CLK) disable iff (SRST)
		RD && ADDR == iparb_pkg::DIFF_STS_ADDR |=> RDATA[5] == $past(ACT_ALARM[3]) && RDATA[1] == $past(ACT_ALARM[2]))
		else $error("activity alarm bits misplaced");

	AST_LOCK_RAISE: assert property (@(posedge CLK) disable iff (SRST)
		timeout |=> lock_alarm[$past(SEL_INPUT)] && irq_sts[$past(SEL_INPUT)])
		else $error("lock alarm not raised on timeout");

	// the pick is judged in the cycle it is made, since the registered index lags a cycle
	AST_SEL_RANK: assert property (@(posedge CLK) disable iff (SRST)
		next_valid |-> rank[next_sel] != 4'h0 && !alarm[next_sel] ##1 SEL_VALID && SEL_INPUT == $past(next_sel))
		else $error("selected input was not qualified");

	AST_SET_WINS: assert property (@(posedge CLK) disable iff (SRST)
		irq_set[iparb_pkg::IRQ_SEL_CHG_BIT] |=> irq_sts[iparb_pkg::IRQ_SEL_CHG_BIT])
		else $error("interrupt event lost");

	// a one written with no event pending clears the sticky bit
	AST_W1C_CLEARS: assert property (@(posedge CLK) disable iff (SRST)
		bus.wr && bus.addr == iparb_pkg::IRQ_STS_ADDR && bus.wdata[iparb_pkg::IRQ_SEL_CHG_BIT] &&
		!irq_set[iparb_pkg::IRQ_SEL_CHG_BIT] |=> !irq_sts[iparb_pkg::IRQ_SEL_CHG_BIT])
		else $error("interrupt status not cleared");

	// differential ranks read back as stored, cleared fields as zero
	AST_DIFF_READ: assert property (@(posedge CLK) disable iff (SRST)
		RD && ADDR == iparb_pkg::DIFF_PRI_ADDR |=> RDATA == $past(pri_diff))
		else $error("differential priority read mismatch");

	// status words share one layout across the three registers
	AST_SE_ACT_BITS: assert property (@(posedge CLK) disable iff (SRST)
		RD && ADDR == iparb_pkg::SE_STS_ADDR |=> RDATA[5] == $past(ACT_ALARM[1]) && RDATA[1] == $past(ACT_ALARM[0]))
		else $error("single-ended activity bits misplaced");

	AST_LOCK_BITS: assert property (@(posedge CLK) disable iff (SRST)
		RD && ADDR == iparb_pkg::SE_STS_ADDR |=> RDATA[4] == $past(lock_alarm[1]) && RDATA[0] == $past(lock_alarm[0]))
		else $error("lock alarm bits misplaced");

	AST_STBY_BITS: assert property (@(posedge CLK) disable iff (SRST)
		RD && ADDR == iparb_pkg::STBY_STS_ADDR |=> RDATA[5:4] == 2'h0 && RDATA[1] == $past(ACT_ALARM[4]))
		else $error("stand-by activity bit misplaced");

	// read data must not linger, software may poll without strobing
	AST_RDATA_IDLE: assert property (@(posedge CLK) disable iff (SRST)
		!RD |=> RDATA == 8'h00)
		else $error("read data stood without a read");

endmodule // iparb_regs

/* File: test/test_iparb_regs.sv */
`timescale 1ns/1ps
module test_iparb_regs;
	logic        clk;
	logic        srst;
	logic  [7:0] addr;
	logic  [7:0] wdata;
	logic        wr;
	logic        rd;
	logic  [7:0] rdata;
	logic  [4:0] act_alarm;
	logic        loop_locked;
	logic        sel_valid;
	logic  [2:0] sel_input;
	logic        irq;
	logic  [7:0] got;
	int          bad_count;
	int          checks_done;
	int          n;
	// row: write address, write data, read address, expected read data
	logic [31:0] rows [9] = '{
		32'h1A_21_19_00,
		32'h1A_21_1A_21,
		32'h19_50_1A_01,
		32'h19_05_1A_00,
		32'h1A_30_19_05,
		32'h19_00_1A_30,
		32'h13_AA_13_00,
		32'h19_21_19_21,
		32'h1A_00_19_21
	};

	// short counts keep the lock timeout at twelve cycles
	iparb_regs #(.TICK_CYCLES(4), .LOCK_TICKS(3)) u_iparb_regs (
		.CLK         (clk),
		.SRST        (srst),
		.ADDR        (addr),
		.WDATA       (wdata),
		.WR          (wr),
		.RD          (rd),
		.RDATA       (rdata),
		.ACT_ALARM   (act_alarm),
		.LOOP_LOCKED (loop_locked),
		.SEL_VALID   (sel_valid),
		.SEL_INPUT   (sel_input),
		.IRQ         (irq)
	);

	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ends just past the taking edge so the write has landed
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// bounded wait for a selection; a hang ends the run
	task automatic wait_sel(input logic [2:0] s, input int lim);
		n = 0;
		while (sel_input !== s && n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (sel_input !== s)
		begin
			bad_count++;
			test_done();
		end
	endtask

	initial
	begin
		srst        = 1'b1;
		addr        = 8'h00;
		wdata       = 8'h00;
		wr          = 1'b0;
		rd          = 1'b0;
		act_alarm   = 5'h00;
		loop_locked = 1'b1;
		bad_count   = 0;
		checks_done = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		// reset values
		rd_reg(8'h19, got); chk(got, 8'h32);
		rd_reg(8'h1A, got); chk(got, 8'h00);
		rd_reg(8'h31, got); chk(got, 8'h00);
		chk({7'h00, irq}, 8'h00);
		// cross-clearing table; ends with ranks 0x21 and 0x00
		foreach (rows[i])
		begin
			wr_reg(rows[i][31:24], rows[i][23:16]);
			rd_reg(rows[i][15:8], got);
			chk(got, rows[i][7:0]);
		end
		// selection follows rank and activity alarms
		wait_sel(3'h0, 4); chk({7'h00, sel_valid}, 8'h01);
		@(posedge clk);
		act_alarm <= 5'h01;
		wait_sel(3'h1, 4); chk({5'h00, sel_input}, 8'h01);
		rd_reg(8'h11, got); chk(got, 8'h02);
		@(posedge clk);
		act_alarm <= 5'h03;
		wait_sel(3'h4, 4); chk({5'h00, sel_input}, 8'h04);
		rd_reg(8'h11, got); chk(got, 8'h22);
		@(posedge clk);
		act_alarm <= 5'h1C;
		wait_sel(3'h0, 4); chk({5'h00, sel_input}, 8'h00);
		rd_reg(8'h14, got); chk(got, 8'h02);
		rd_reg(8'h12, got); chk(got, 8'h22);
		@(posedge clk);
		act_alarm <= 5'h00;
		wr_reg(8'h19, 8'h20);
		wait_sel(3'h1, 4); chk({5'h00, sel_input}, 8'h01);
		wr_reg(8'h1A, 8'h01);
		wait_sel(3'h2, 4); chk({5'h00, sel_input}, 8'h02);
		rd_reg(8'h1C, got); chk(got, 8'h82);
		rd_reg(8'h19, got); chk(got, 8'h20);
		wr_reg(8'h19, 8'h21);
		wait_sel(3'h0, 4); chk({5'h00, sel_input}, 8'h00);
		// lock timeout moves selection and raises the interrupt
		wr_reg(8'h30, 8'hFF);
		wr_reg(8'h31, 8'h3F);
		chk({7'h00, irq}, 8'h00);
		@(posedge clk);
		loop_locked <= 1'b0;
		wait_sel(3'h1, 100); chk({5'h00, sel_input}, 8'h01);
		// three ticks of four cycles, tick phase unknown, one more to register the move
		chk({7'h00, n >= 10 && n <= 13}, 8'h01);
		@(posedge clk);
		loop_locked <= 1'b1;
		rd_reg(8'h11, got); chk(got, 8'h01);
		chk({7'h00, irq}, 8'h01);
		rd_reg(8'h30, got); chk(got, 8'h21);
		wr_reg(8'h31, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wr_reg(8'h31, 8'h01);
		chk({7'h00, irq}, 8'h01);
		wr_reg(8'h30, 8'h21);
		chk({7'h00, irq}, 8'h00);
		rd_reg(8'h30, got); chk(got, 8'h00);
		// reset in mid-run restores defaults
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		chk({4'h0, sel_valid, sel_input}, 8'h00);
		srst <= 1'b0;
		rd_reg(8'h19, got); chk(got, 8'h32);
		rd_reg(8'h11, got); chk(got, 8'h00);
		// read data stands one cycle only
		@(posedge clk);
		#1;
		chk(rdata, 8'h00);
		chk({7'h00, irq}, 8'h00);
		test_done();
	end
endmodule // test_iparb_regs
